// *** design/trfm_edge.sv ***
`default_nettype none
// Rising-edge detector on an already synchronised level
module trfm_edge (
    input  wire logic i_clock,
    input  wire logic i_reset_n,
    input  wire logic i_level,
    output logic      o_pulse
);
    logic prev;   // Level one cycle ago

    // Remember level and flag rising edge
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev    <= 1'b0;
            o_pulse <= 1'b0;
        end else begin
            prev    <= i_level;
            o_pulse <= i_level & ~prev;
        end
    end
endmodule
`default_nettype wire

// *** design/trfm_pkg.sv ***
`default_nettype none
package trfm_pkg;
    // ------------------------------------------------------------------
    // Command and control block layout
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_READ_FILE_MARK = 8'ha0;   // Command code
    localparam logic [7:0]  REF_TAPE_START     = 8'h00;   // Start at tape start position
    localparam logic [7:0]  REF_CURRENT        = 8'h01;   // Start at current position
    localparam int          CB_CMD_OFS         = 0;       // Byte offsets in io_control_block
    localparam int          CB_REF_OFS         = 1;
    localparam int          CB_SKIP_OFS        = 6;       // After 4 unused bytes
    localparam int          CB_STATUS_OFS      = 12;      // After 4 more unused bytes
    localparam int          CB_ERROR_OFS       = 13;
    localparam int          CB_DSTAT_OFS       = 14;      // Six drive-status bytes
    localparam int          CB_SKIPPED_OFS     = 20;
    localparam int          CB_LEN             = 22;
    // ------------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL     = 8'h00;  // W: bit0 go, bit1 drive select
    localparam logic [7:0]  REG_CMD      = 8'h04;  // [7:0] command, [15:8] reference point
    localparam logic [7:0]  REG_SKIP     = 8'h08;  // [15:0] skip count
    localparam logic [7:0]  REG_RESULT   = 8'h0c;  // [7:0] status, [15:8] error, [31:16] skipped
    localparam logic [7:0]  REG_DSTAT_LO = 8'h10;  // Drive status bytes 0..3
    localparam logic [7:0]  REG_DSTAT_HI = 8'h14;  // Drive status bytes 4..5
    localparam logic [7:0]  REG_FIELD    = 8'h18;  // R: live tape conditions
    localparam int          CTRL_GO      = 0;
    localparam int          CTRL_SELECT  = 1;
    // ------------------------------------------------------------------
    // Status and error bit positions
    // ------------------------------------------------------------------
    localparam int ST_BUSY = 0, ST_DONE = 1, ST_REJECT = 2, ST_FOUND = 3;
    localparam int ST_SELECTED = 4, ST_AT_START = 5;
    localparam int ER_UNSELECTED = 0, ER_NO_CASSETTE = 1, ER_ILLEGAL = 2;
    localparam int ER_FAULT = 3, ER_TIMEOUT = 4, ER_UNRECOVERABLE = 5;
    localparam int ER_BAD_CODE = 6;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_HZ        = 40_000_000;
    localparam int START_TIMEOUT_MS = 500;
    localparam int START_TIMEOUT_CYC = CLOCK_HZ / 1000 * START_TIMEOUT_MS;  // Longest time, rounds down
    localparam int MAX_ATTEMPTS    = 16;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TRFM_IDLE   = 3'b000,
        TRFM_START  = 3'b001,
        TRFM_SKIP   = 3'b011,
        TRFM_SEARCH = 3'b010,
        TRFM_REWIND = 3'b110,
        TRFM_DONE   = 3'b111
    } trfm_state_t;
    typedef struct packed {                 // Tape transport conditions from the mechanism
        logic cassette_in;
        logic writing;
        logic fault;
        logic moving;
        logic segment;                      // Pulse per segment passed
        logic file_mark;                    // Pulse on file mark read
        logic mark_error;                   // Pulse on a failed file-mark read
        logic at_start;
    } trfm_tape_t;
    typedef struct packed {                 // Drive commands to the mechanism
        logic run;
        logic rewind;
        logic to_start;
    } trfm_motor_t;
endpackage
`default_nettype wire

// *** design/trfm_sync.sv ***
`default_nettype none
// Two-flop synchroniser for a bundle of level signals
module trfm_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;   // First stage, read only by second stage

    // Two flops in series
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule
`default_nettype wire

// *** design/trfm_top.sv ***
// Operation
// - Run tape forward until a file mark.
// - Recognise command code binary 10100000.
// - Control block byte layout in order.
// - Skip requested segments before searching.
// - Report segments actually skipped.
// - Errors set error bits, detail status; a bad command code sets only ER_BAD_CODE, with no detail status.
// - Reject: unselected, no cassette, writing, fault.
// - Eject terminates; no start is timeout.
// - Sixteen failed reads: error and rewind.
// - Report drive condition in status byte.
`default_nettype none
module trfm_top
    import trfm_pkg::*;
#(
    parameter int START_TIMEOUT = START_TIMEOUT_CYC   // Cycles allowed for tape to start
) (
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Tape mechanism
    input  wire trfm_tape_t  i_tape,
    output trfm_motor_t      o_motor,
    output logic             o_done
);
    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    trfm_tape_t tape;          // Synchronised tape conditions
    logic       seg_pulse;     // One pulse per segment
    logic       mark_pulse;    // One pulse per file mark
    logic       merr_pulse;    // One pulse per failed mark read

    trfm_sync #(.WIDTH($bits(trfm_tape_t))) u_sync (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   (i_tape),
        .o_sync    (tape)
    );
    trfm_edge u_seg (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_level   (tape.segment),
        .o_pulse   (seg_pulse)
    );
    trfm_edge u_mark (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_level   (tape.file_mark),
        .o_pulse   (mark_pulse)
    );
    trfm_edge u_merr (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_level   (tape.mark_error),
        .o_pulse   (merr_pulse)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic        selected;        // Drive select has been issued
    logic [7:0]  cmd_code;        // Command byte of io_control_block
    logic [7:0]  ref_point;       // Reference point byte
    logic [15:0] skip_count;      // Segments to skip
    logic [7:0]  status_byte;     // General drive condition
    logic [7:0]  error_byte;      // Error bits
    logic [47:0] drive_status;    // Six detail bytes
    logic [15:0] skipped;         // Segments actually passed
    trfm_state_t state;           // Command sequencer
    logic [31:0] timer;           // Tape start timeout counter
    logic [4:0]  attempts;        // Failed file-mark reads
    logic        go;              // One-cycle start request
    logic        apb_write;       // Write access phase
    logic        apb_read;        // Read access phase
    logic        addr_ok;         // Address is mapped
    logic [31:0] next_rdata;      // Read mux

    assign apb_write = psel & penable & pwrite;
    assign apb_read  = psel & penable & ~pwrite;
    assign addr_ok   = paddr inside {REG_CTRL, REG_CMD, REG_SKIP, REG_RESULT,
                                      REG_DSTAT_LO, REG_DSTAT_HI, REG_FIELD};

    // ------------------------------------------------------------------
    // APB answer: zero wait states
    // ------------------------------------------------------------------

    // Read data mux, unmapped reads as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            REG_CTRL:     next_rdata = {30'h0, selected, 1'b0};
            REG_CMD:      next_rdata = {16'h0, ref_point, cmd_code};
            REG_SKIP:     next_rdata = {16'h0, skip_count};
            REG_RESULT:   next_rdata = {skipped, error_byte, status_byte};
            REG_DSTAT_LO: next_rdata = drive_status[31:0];
            REG_DSTAT_HI: next_rdata = {16'h0, drive_status[47:32]};
            REG_FIELD:    next_rdata = {24'h0, tape};
            default:      next_rdata = 32'h0000_0000;
        endcase
    end

    // Registered answer in the setup cycle, pready in the access cycle
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata  <= next_rdata;
        end
    end

    // Software-written parameter bytes of the control block
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            selected   <= 1'b0;
            cmd_code   <= 8'h00;
            ref_point  <= REF_TAPE_START;
            skip_count <= 16'h0000;
        end else if (apb_write && pready) begin
            unique case (paddr)
                REG_CTRL: selected <= pwdata[CTRL_SELECT];
                REG_CMD: begin
                    cmd_code  <= pwdata[7:0];
                    ref_point <= pwdata[15:8];
                end
                REG_SKIP: skip_count <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Start pulse from control register
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            go <= 1'b0;
        end else begin
            go <= apb_write & pready & (paddr == REG_CTRL) & pwdata[CTRL_GO];
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------

    // State, counters and results
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state        <= TRFM_IDLE;
            timer        <= 32'h0;
            attempts     <= 5'h0;
            skipped      <= 16'h0000;
            error_byte   <= 8'h00;
            drive_status <= 48'h0;
            o_motor      <= '0;
            o_done       <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (state)
                // Wait for a command
                TRFM_IDLE: begin
                    o_motor <= '0;
                    if (go) begin
                        error_byte   <= 8'h00;
                        drive_status <= 48'h0;
                        skipped      <= 16'h0000;
                        attempts     <= 5'h0;
                        timer        <= 32'h0;
                        // Rejection checks at issue time
                        if (cmd_code != CMD_READ_FILE_MARK) begin
                            error_byte[ER_BAD_CODE] <= 1'b1;
                            state <= TRFM_DONE;
                        end else if (!selected || !tape.cassette_in ||
                                     tape.writing || tape.fault) begin
                            error_byte[ER_UNSELECTED]  <= ~selected;
                            error_byte[ER_NO_CASSETTE] <= ~tape.cassette_in;
                            error_byte[ER_ILLEGAL]     <= tape.writing;
                            error_byte[ER_FAULT]       <= tape.fault;
                            drive_status[7:0] <= {4'h0, tape.fault, tape.writing,
                                                  ~tape.cassette_in, ~selected};
                            state <= TRFM_DONE;
                        end else begin
                            o_motor.run      <= 1'b1;
                            o_motor.to_start <= (ref_point == REF_TAPE_START);
                            state <= TRFM_START;
                        end
                    end
                end

                // Wait for motion
                TRFM_START: begin
                    timer <= timer + 32'h1;
                    if (!tape.cassette_in) begin
                        error_byte[ER_NO_CASSETTE] <= 1'b1;
                        drive_status[15:8] <= 8'h01;
                        o_motor <= '0;
                        state <= TRFM_DONE;
                    end else if (tape.moving) begin
                        o_motor.to_start <= 1'b0;
                        state <= (skip_count == 16'h0000) ? TRFM_SEARCH : TRFM_SKIP;
                    end else if (timer >= START_TIMEOUT[31:0]) begin
                        error_byte[ER_TIMEOUT] <= 1'b1;
                        drive_status[15:8] <= 8'h02;
                        o_motor <= '0;
                        state <= TRFM_DONE;
                    end
                end

                // Count segments
                TRFM_SKIP: begin
                    if (!tape.cassette_in) begin
                        error_byte[ER_NO_CASSETTE] <= 1'b1;
                        drive_status[15:8] <= 8'h01;
                        o_motor <= '0;
                        state <= TRFM_DONE;
                    end else if (seg_pulse) begin
                        skipped <= skipped + 16'h1;
                        if (skipped + 16'h1 == skip_count) begin
                            state <= TRFM_SEARCH;
                        end
                    end
                end

                // Look for a mark
                TRFM_SEARCH: begin
                    if (!tape.cassette_in) begin
                        error_byte[ER_NO_CASSETTE] <= 1'b1;
                        drive_status[15:8] <= 8'h01;
                        o_motor <= '0;
                        state <= TRFM_DONE;
                    end else if (mark_pulse) begin
                        o_motor <= '0;
                        state <= TRFM_DONE;
                    end else if (merr_pulse) begin
                        attempts <= attempts + 5'h1;
                        if (attempts + 5'h1 == 5'(MAX_ATTEMPTS)) begin
                            error_byte[ER_UNRECOVERABLE] <= 1'b1;
                            drive_status[23:16] <= 8'(MAX_ATTEMPTS);
                            o_motor.run    <= 1'b0;
                            o_motor.rewind <= 1'b1;
                            state <= TRFM_REWIND;
                        end
                    end
                end

                // Back to start
                TRFM_REWIND: begin
                    if (tape.at_start || !tape.cassette_in) begin
                        o_motor <= '0;
                        state <= TRFM_DONE;
                    end
                end

                // Signal completion
                TRFM_DONE: begin
                    o_done <= 1'b1;
                    state  <= TRFM_IDLE;
                end

                // Illegal codes
                default: state <= TRFM_IDLE;
            endcase
        end
    end

    // General drive condition byte
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_byte <= 8'h00;
        end else begin
            // Live condition bits
            status_byte[ST_BUSY]     <= (state != TRFM_IDLE);
            status_byte[ST_SELECTED] <= selected;
            status_byte[ST_AT_START] <= tape.at_start;
            if (go) begin
                status_byte[ST_DONE]   <= 1'b0;
                status_byte[ST_REJECT] <= 1'b0;
                status_byte[ST_FOUND]  <= 1'b0;
            end else if (state == TRFM_DONE) begin
                // Outcome of the command
                status_byte[ST_DONE]   <= 1'b1;
                // Terminations leave a cause in bytes 1 and 2
                status_byte[ST_REJECT] <= (error_byte != 8'h00) & (drive_status[23:8] == 16'h0000);
                status_byte[ST_FOUND]  <= (error_byte == 8'h00);
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/trfm_bench.sv ***
`default_nettype none
module trfm_bench
    import trfm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TMO = 50;    // Shortened start timeout
    logic        i_clock = 1'b0, i_reset_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, o_done, er;
    trfm_tape_t  tape;
    trfm_motor_t motor;
    logic        cas = 1'b1, wrt = 1'b0, flt = 1'b0, stall = 1'b0, saw_rw = 1'b0, saw_ts = 1'b0;
    logic [7:0]  segs = 8'h00, errs = 8'h00;
    int          n_errors = 0, checks_done = 0, cyc = 0;
    trfm_top #(.START_TIMEOUT(TMO)) dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .i_tape(tape), .o_motor(motor), .o_done(o_done));
    trfm_tape_model tape_mdl (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_motor(motor),
        .i_cassette(cas), .i_writing(wrt), .i_fault(flt), .i_stall(stall), .i_segs(segs),
        .i_errs(errs), .o_tape(tape));
    always #12.5 i_clock = ~i_clock;
    // Watchdog and motor monitors
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (motor.rewind) saw_rw <= 1'b1;
        if (motor.to_start) saw_ts <= 1'b1;
        if (cyc == 30000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer, then an idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1) @(posedge i_clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic start(input logic sel, input logic [7:0] code, refp, input logic [15:0] skip);
        apb(1'b1, REG_CMD, {16'h0, refp, code});
        apb(1'b1, REG_SKIP, {16'h0, skip});
        apb(1'b1, REG_CTRL, {30'h0, sel, 1'b1});
    endtask
    task automatic finish(input logic [7:0] err, st);
        while (o_done !== 1'b1) @(posedge i_clock);
        apb(1'b0, REG_RESULT, 32'h0);
        chk("error byte", 32'(err), 32'(rd[15:8]));
        chk("status byte", 32'(st), 32'(rd[7:0] & 8'h0f));
    endtask
    task automatic rej(input logic sel, c, w, f, input logic [7:0] code, e);
        cas <= c;
        wrt <= w;
        flt <= f;
        repeat (6) @(posedge i_clock);
        start(sel, code, REF_CURRENT, 16'h0);
        finish(e, 8'h06);
        cas <= 1'b1;
        wrt <= 1'b0;
        flt <= 1'b0;
        repeat (6) @(posedge i_clock);
    endtask
    task automatic t_regs();
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped error", 32'h1, 32'(er));
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, REG_SKIP, 32'h0000_1234);
        apb(1'b0, REG_SKIP, 32'h0);
        chk("skip field", 32'h1234, 32'(rd[15:0]));
        apb(1'b1, REG_RESULT, 32'hffff_ffff);
        apb(1'b0, REG_RESULT, 32'h0);
        chk("result read only", 32'h20, rd);
        apb(1'b1, REG_CTRL, 32'h2);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("select", 32'h1, 32'(rd[1]));
        $display("test registers done");
    endtask
    task automatic t_reject();
        rej(1'b0, 1'b1, 1'b0, 1'b0, CMD_READ_FILE_MARK, 8'h01);
        rej(1'b1, 1'b0, 1'b0, 1'b0, CMD_READ_FILE_MARK, 8'h02);
        rej(1'b1, 1'b1, 1'b1, 1'b0, CMD_READ_FILE_MARK, 8'h04);
        rej(1'b1, 1'b1, 1'b0, 1'b1, CMD_READ_FILE_MARK, 8'h08);
        rej(1'b1, 1'b1, 1'b0, 1'b0, 8'h60, 8'h40);
        rej(1'b1, 1'b1, 1'b0, 1'b0, 8'h80, 8'h40);
        $display("test reject done");
    endtask
    task automatic t_find();
        segs <= 8'd3;
        errs <= 8'd15;
        saw_ts <= 1'b0;
        start(1'b1, CMD_READ_FILE_MARK, REF_TAPE_START, 16'd3);
        finish(8'h00, 8'h0a);
        chk("skipped", 32'd3, 32'(rd[31:16]));
        chk("from tape start", 32'h1, 32'(saw_ts));
        segs <= 8'd0;
        errs <= 8'd0;
        start(1'b1, CMD_READ_FILE_MARK, REF_CURRENT, 16'd0);
        finish(8'h00, 8'h0a);
        chk("skipped none", 32'd0, 32'(rd[31:16]));
        $display("test find done");
    endtask
    task automatic t_unrec();
        errs <= 8'd16;
        saw_rw <= 1'b0;
        start(1'b1, CMD_READ_FILE_MARK, REF_CURRENT, 16'd0);
        finish(8'h20, 8'h02);
        chk("rewound", 32'h1, 32'(saw_rw));
        apb(1'b0, REG_DSTAT_LO, 32'h0);
        chk("attempts", 32'd16, 32'(rd[23:16]));
        errs <= 8'd0;
        $display("test unrecoverable done");
    endtask
    task automatic t_abort(input logic ej, input logic [7:0] err, cause);
        segs <= 8'd200;
        stall <= !ej;
        start(1'b1, CMD_READ_FILE_MARK, REF_CURRENT, 16'd200);
        if (ej) repeat (60) @(posedge i_clock);
        cas <= !ej;
        finish(err, 8'h02);
        apb(1'b0, REG_DSTAT_LO, 32'h0);
        chk("abort cause", 32'(cause), 32'(rd[15:8]));
        cas <= 1'b1;
        stall <= 1'b0;
        segs <= 8'd0;
        repeat (6) @(posedge i_clock);
        $display("test abort done");
    endtask
    initial begin
        repeat (10) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        t_regs();
        t_reject();
        t_find();
        t_unrec();
        t_abort(1'b1, 8'h02, 8'h01);
        t_abort(1'b0, 8'h10, 8'h02);
        results();
    end
endmodule
bind trfm_top trfm_check #(.START_TIMEOUT(START_TIMEOUT)) u_check (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_tape(i_tape),
    .o_motor(o_motor), .o_done(o_done));
`default_nettype wire

// *** tb/trfm_check_properties.sv ***
`default_nettype none
module trfm_check
    import trfm_pkg::*;
#(
    parameter int START_TIMEOUT = 50    // Cycles allowed for the tape to start
) (
    input wire logic        i_clock,
    input wire logic        i_reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire trfm_tape_t  i_tape,
    input wire trfm_motor_t o_motor,
    input wire logic        o_done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    logic       go_wr;      // Accepted write that sets go
    logic [3:0] out_n;      // Cycles without cassette, saturating
    int         stall_n;    // Cycles running with no tape motion
    assign go_wr = psel && penable && pready && pwrite && paddr == REG_CTRL && pwdata[CTRL_GO];
    // Counts how long the cassette has been out
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) out_n <= 4'h0;
        else if (i_tape.cassette_in) out_n <= 4'h0;
        else if (out_n != 4'hf) out_n <= out_n + 4'h1;
    end
    // Counts how long the motor has been asked to run without motion
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) stall_n <= 0;
        else stall_n <= (o_motor.run && !i_tape.moving) ? stall_n + 1 : 0;
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence ended_s;
        ##[1:5] o_done;
    endsequence
    apb_answer_a: assert property (setup_s |=> pready) else $error("no answer after setup");
    ready_once_a: assert property (pready |=> !pready) else $error("ready held too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    done_pulse_a: assert property (o_done |=> !o_done) else $error("done longer than one cycle");
    reject_quiet_a: assert property (go_wr && out_n > 4'h5 |-> !o_motor.run throughout ended_s)
        else $error("command without cassette not refused");
    eject_stop_a: assert property ($fell(i_tape.cassette_in) && o_motor.run |-> ##[1:6] !o_motor.run)
        else $error("motor kept running after eject");
    start_limit_a: assert property (stall_n <= START_TIMEOUT + 8) else $error("start wait too long");
    rewind_end_a: assert property ($rose(i_tape.at_start) && o_motor.rewind |-> ##[1:6] !o_motor.rewind)
        else $error("rewind not ended at tape start");
    mark_stop_a: assert property (o_motor.run && $rose(i_tape.file_mark) |-> ##[1:8] o_done)
        else $error("file mark did not end command");
    done_still_a: assert property (o_done |=> !o_motor.run) else $error("motor running after done");
endmodule
`default_nettype wire

// *** tb/trfm_tape_model.sv ***
`default_nettype none
// Behavioural tape transport: segments, failed reads, then a file mark
module trfm_tape_model
    import trfm_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire trfm_motor_t i_motor,
    input  wire logic        i_cassette,
    input  wire logic        i_writing,
    input  wire logic        i_fault,
    input  wire logic        i_stall,    // Tape refuses to move
    input  wire logic [7:0]  i_segs,     // Segments before the mark
    input  wire logic [7:0]  i_errs,     // Failed mark reads before it
    output trfm_tape_t       o_tape
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       mv, seg, fm, me, ats;
    logic [2:0] tick;    // One event every eight cycles
    logic [8:0] n;       // Events since the motor started
    logic [4:0] rw;      // Rewind duration
    assign o_tape = {i_cassette, i_writing, i_fault, mv, seg, fm, me, ats};
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {mv, seg, fm, me, tick, n, rw} <= '0;
            ats <= 1'b1;
        end else begin
            mv <= (i_motor.run || i_motor.rewind) && i_cassette && !i_stall;
            seg <= 1'b0;
            fm <= 1'b0;
            me <= 1'b0;
            tick <= (i_motor.run && mv) ? tick + 3'h1 : 3'h0;
            if (!i_motor.run) n <= 9'h0;
            if (i_motor.run && mv && tick == 3'h7) begin
                n <= n + 9'h1;
                if (n < {1'b0, i_segs}) seg <= 1'b1;
                else if (n < i_segs + i_errs) me <= 1'b1;
                else fm <= 1'b1;
            end
            rw <= !i_motor.rewind ? 5'h0 : (rw == 5'h1f ? rw : rw + 5'h1);
            if (i_motor.rewind && rw == 5'h14) ats <= 1'b1;
            else if (i_motor.run && mv) ats <= 1'b0;
        end
    end
endmodule
`default_nettype wire
